// file: alu_core.sv
// Arithmetic, logic and shift datapath with its register file and flags.
//
// Implementation choices: the strobed register port and the placing of the registers.

// Behaviour
// - Add or subtract registers; immediate only adds.
// - Word add and subtract are register only.
// - Carry add and borrow subtract, byte only.
// - Byte step up or down by one.
// - Word step by one or two.
// - Decimal adjust using current flags.
// - Unsigned 8x8 multiply, full 16-bit product.
// - Unsigned 16/8 divide, quotient and remainder.
// - Compare sets flags, stores nothing.
// - Word compare is register only.
// - Negate as zero minus register.
// - Byte AND, OR, XOR with register or immediate.
// - Invert every bit of register.
// - Arithmetic shift by one position.
// - Logical shift by one position.
// - Rotate by one, bit wraps around.
// - Nine-bit rotate through carry.
// - Flags hold half carry, negative, zero, overflow, carry.
module alu_core (
  // Clock and reset.
  input  wire logic              sys_clk,
  input  wire logic              srst,
  // Register bus.
  input  wire logic [4:0]        busAddr,
  input  wire logic [7:0]        busWdata,
  input  wire logic              busWr,
  input  wire logic              busRd,
  output logic      [7:0]        busRdata,
  // Instruction port.
  input  wire logic              reqValid,
  input  wire alu_pkg::alu_req_s req,
  output logic                   reqError,
  output logic      [4:0]        condFlags
);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]  gpr_ff [16];
  logic [4:0]  flags_ff;
  logic [7:0]  rdata_ff;
  logic        error_ff;

  logic [7:0]  a8;
  logic [7:0]  b8;
  logic [15:0] wa;
  logic [15:0] wb;
  logic [3:0]  hiIdx;
  logic [3:0]  loIdx;
  logic        cOld;
  logic        hOld;

  // Adds a plus b plus carry in, with b inverted for subtraction.
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic ci, input logic sub);
    logic [7:0] bb;
    logic [8:0] s;
    logic [4:0] l;
    bb = sub ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
    l = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
    return {s[8] ^ sub, (a[7] == bb[7]) && (s[7] != a[7]), l[4] ^ sub, s[7:0]};
  endfunction

  // Word version, half carry taken from bit 11.
  function automatic logic [18:0] add16(input logic [15:0] a, input logic [15:0] b,
                                        input logic ci, input logic sub);
    logic [15:0] bb;
    logic [16:0] s;
    logic [12:0] l;
    bb = sub ? ~b : b;
    s = {1'b0, a} + {1'b0, bb} + {16'h0000, ci};
    l = {1'b0, a[11:0]} + {1'b0, bb[11:0]} + {12'h000, ci};
    return {s[16] ^ sub, (a[15] == bb[15]) && (s[15] != a[15]), l[12] ^ sub, s[15:0]};
  endfunction

  // ****************************************
  // Operand selection
  // ****************************************
  assign hiIdx = {req.dst[2:0], 1'b0};
  assign loIdx = {req.dst[2:0], 1'b1};
  assign a8    = gpr_ff[req.dst];
  assign b8    = req.immSel ? req.imm : gpr_ff[req.src];
  assign wa    = {gpr_ff[hiIdx], gpr_ff[loIdx]};
  assign wb    = {gpr_ff[{req.src[2:0], 1'b0}], gpr_ff[{req.src[2:0], 1'b1}]};
  assign cOld  = flags_ff[alu_pkg::FLAG_C];
  assign hOld  = flags_ff[alu_pkg::FLAG_H];

  // ****************************************
  // Legality decode
  // ****************************************
  logic immOk;
  logic wordOk;
  logic inherentWord;
  logic illegal;
  logic go;

  assign immOk = req.op inside {alu_pkg::OP_ADD, alu_pkg::OP_ADDC, alu_pkg::OP_SUBB,
                                alu_pkg::OP_COMPARE, alu_pkg::OP_AND, alu_pkg::OP_OR,
                                alu_pkg::OP_XOR};
  assign wordOk = req.op inside {alu_pkg::OP_ADD, alu_pkg::OP_SUB, alu_pkg::OP_COMPARE};
  assign inherentWord = req.op inside {alu_pkg::OP_WINC, alu_pkg::OP_WDEC,
                                       alu_pkg::OP_MUL, alu_pkg::OP_DIV};
  assign illegal = (req.immSel && (!immOk || req.word || inherentWord))
                 || (req.word && !wordOk && !inherentWord);
  assign go = reqValid && !illegal;

  // ****************************************
  // Arithmetic units
  // ****************************************
  logic        isSub;
  logic [7:0]  arA;
  logic [7:0]  arB;
  logic        arCi;
  logic [10:0] s8;
  logic [15:0] wStep;
  logic [18:0] s16;
  logic [7:0]  quot;
  logic [7:0]  rem;
  logic        divOvf;

  assign isSub = req.op inside {alu_pkg::OP_SUB, alu_pkg::OP_SUBB, alu_pkg::OP_DECB,
                                alu_pkg::OP_COMPARE, alu_pkg::OP_NEGATE, alu_pkg::OP_WDEC};
  assign arA  = (req.op == alu_pkg::OP_NEGATE) ? 8'h00 : a8;
  assign arB  = (req.op == alu_pkg::OP_NEGATE) ? a8
              : (req.op inside {alu_pkg::OP_INCB, alu_pkg::OP_DECB}) ? 8'h01 : b8;
  assign arCi = (req.op == alu_pkg::OP_ADDC) ? cOld
              : (req.op == alu_pkg::OP_SUBB) ? ~cOld : isSub;
  assign s8   = add8(arA, arB, arCi, isSub);
  // word step by one or two
  assign wStep = (req.op inside {alu_pkg::OP_WINC, alu_pkg::OP_WDEC})
               ? (req.step2 ? 16'h0002 : 16'h0001) : wb;
  assign s16  = add16(wa, wStep, isSub, isSub);

  div_unit u_div (
    .dividend  (wa),
    .divisor   (b8),
    .quotient  (quot),
    .remainder (rem),
    .overflow  (divOvf)
  );

  // ****************************************
  // Result and flag formation
  // ****************************************
  logic [15:0] nxtRes;
  logic [4:0]  nxtFlags;
  logic        nxtWrB;
  logic        nxtWrW;

  // Picks the result, write size and new flags for the current operation.
  always_comb begin
    logic [7:0] r;
    logic       co;
    r = 8'h00;
    co = cOld;
    nxtRes = 16'h0000;
    nxtWrB = 1'b0;
    nxtWrW = 1'b0;
    nxtFlags = flags_ff;
    unique case (req.op)
      alu_pkg::OP_ADD, alu_pkg::OP_SUB, alu_pkg::OP_ADDC, alu_pkg::OP_SUBB,
      alu_pkg::OP_COMPARE, alu_pkg::OP_NEGATE: begin
        if (req.word) begin
          nxtRes = s16[15:0];
          nxtWrW = (req.op != alu_pkg::OP_COMPARE);
          nxtFlags = {s16[16], s16[15], s16[15:0] == 16'h0000, s16[17], s16[18]};
        end else begin
          nxtRes = {8'h00, s8[7:0]};
          nxtWrB = (req.op != alu_pkg::OP_COMPARE);
          nxtFlags = {s8[8], s8[7], s8[7:0] == 8'h00, s8[9], s8[10]};
          // Carry chains keep zero only while every part is zero.
          if (req.op inside {alu_pkg::OP_ADDC, alu_pkg::OP_SUBB})
            nxtFlags[alu_pkg::FLAG_Z] = flags_ff[alu_pkg::FLAG_Z] && (s8[7:0] == 8'h00);
        end
      end
      alu_pkg::OP_INCB, alu_pkg::OP_DECB: begin
        nxtRes = {8'h00, s8[7:0]};
        nxtWrB = 1'b1;
        nxtFlags = {hOld, s8[7], s8[7:0] == 8'h00, s8[9], cOld};
      end
      alu_pkg::OP_WINC, alu_pkg::OP_WDEC: begin
        nxtRes = s16[15:0];
        nxtWrW = 1'b1;
      end
      alu_pkg::OP_DADJ_ADD, alu_pkg::OP_DADJ_SUB: begin
        if (req.op == alu_pkg::OP_DADJ_ADD) begin
          co = cOld || (a8 > 8'h99);
          r = a8 + {(co ? 4'h6 : 4'h0), ((hOld || a8[3:0] > 4'h9) ? 4'h6 : 4'h0)};
        end else begin
          r = a8 - {(cOld ? 4'h6 : 4'h0), (hOld ? 4'h6 : 4'h0)};
        end
        nxtRes = {8'h00, r};
        nxtWrB = 1'b1;
        nxtFlags = {hOld, r[7], r == 8'h00, flags_ff[alu_pkg::FLAG_V], co};
      end
      alu_pkg::OP_MUL: begin
        nxtRes = {8'h00, wa[7:0]} * {8'h00, b8};
        nxtWrW = 1'b1;
      end
      alu_pkg::OP_DIV: begin
        nxtRes = {rem, quot};
        nxtWrW = !divOvf;
        nxtFlags[alu_pkg::FLAG_N] = b8[7];
        nxtFlags[alu_pkg::FLAG_Z] = (b8 == 8'h00);
        nxtFlags[alu_pkg::FLAG_V] = divOvf;
      end
      alu_pkg::OP_AND, alu_pkg::OP_OR, alu_pkg::OP_XOR, alu_pkg::OP_INVERT: begin
        r = (req.op == alu_pkg::OP_AND) ? (a8 & b8)
          : (req.op == alu_pkg::OP_OR)  ? (a8 | b8)
          : (req.op == alu_pkg::OP_XOR) ? (a8 ^ b8) : ~a8;
        nxtRes = {8'h00, r};
        nxtWrB = 1'b1;
        nxtFlags = {hOld, r[7], r == 8'h00, 1'b0, cOld};
      end
      default: begin
        unique case (req.op)
          alu_pkg::OP_ASL, alu_pkg::OP_LSL: {co, r} = {a8, 1'b0};
          alu_pkg::OP_ASR:   {r, co} = {a8[7], a8};
          alu_pkg::OP_LSR:   {r, co} = {1'b0, a8};
          alu_pkg::OP_ROT_L: {co, r} = {a8[7], a8[6:0], a8[7]};
          alu_pkg::OP_ROT_R: {r, co} = {a8[0], a8[7:1], a8[0]};
          alu_pkg::OP_ROTC_L: {co, r} = {a8, cOld};
          default:           {r, co} = {cOld, a8};
        endcase
        nxtRes = {8'h00, r};
        nxtWrB = 1'b1;
        nxtFlags = {hOld, r[7], r == 8'h00,
                    (req.op == alu_pkg::OP_ASL) && (a8[7] ^ a8[6]), co};
      end
    endcase
  end

  // ****************************************
  // Register file and flags
  // ****************************************
  logic busWrGpr;
  logic busWrFlags;
  logic [7:0] rdSel;

  // Bus writes give way to an instruction in the same cycle.
  assign busWrGpr   = busWr && !reqValid && (busAddr <= alu_pkg::ADDR_GPR_LAST);
  assign busWrFlags = busWr && !reqValid && (busAddr == alu_pkg::ADDR_FLAGS);
  assign rdSel = (busAddr <= alu_pkg::ADDR_GPR_LAST) ? gpr_ff[busAddr[3:0]]
               : (busAddr == alu_pkg::ADDR_FLAGS) ? {3'h0, flags_ff} : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < 16; i++) gpr_ff[i] <= alu_pkg::GPR_RESET;
    end else if (go && nxtWrW) begin
      gpr_ff[hiIdx] <= nxtRes[15:8];
      gpr_ff[loIdx] <= nxtRes[7:0];
    end else if (go && nxtWrB) begin
      gpr_ff[req.dst] <= nxtRes[7:0];
    end else if (busWrGpr) begin
      gpr_ff[busAddr[3:0]] <= busWdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) flags_ff <= alu_pkg::FLAGS_RESET;
    else if (go) flags_ff <= nxtFlags;
    else if (busWrFlags) flags_ff <= busWdata[4:0];
  end

  // Read data stand one cycle only; a refused request pulses its error.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata_ff <= 8'h00;
      error_ff <= 1'b0;
    end else begin
      rdata_ff <= busRd ? rdSel : 8'h00;
      error_ff <= reqValid && illegal;
    end
  end

  assign busRdata  = rdata_ff;
  assign reqError  = error_ff;
  assign condFlags = flags_ff;

  // ****************************************
  // Checks
  // ****************************************
  alu_pkg::alu_req_s chkReq_ff;
  logic [7:0]  chkA_ff;
  logic [7:0]  chkB_ff;
  logic [15:0] chkW_ff;
  logic        chkC_ff;
  logic        chkGo_ff;
  logic [7:0]  dstNow;
  logic [15:0] wordNow;

  // Operands as they stood when the last instruction was taken.
  always_ff @(posedge sys_clk) begin
    chkReq_ff <= req;
    chkA_ff <= a8;
    chkB_ff <= b8;
    chkW_ff <= wa;
    chkC_ff <= cOld;
    chkGo_ff <= go && !srst;
  end

  assign dstNow  = gpr_ff[chkReq_ff.dst];
  assign wordNow = {gpr_ff[{chkReq_ff.dst[2:0], 1'b0}], gpr_ff[{chkReq_ff.dst[2:0], 1'b1}]};

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_add_byte: assert property (chkGo_ff && chkReq_ff.op == alu_pkg::OP_ADD && !chkReq_ff.word
    |-> dstNow == 8'(chkA_ff + chkB_ff)) else $error("byte add result wrong");
  a_word_imm_refused: assert property (reqValid && req.word && req.immSel
    |=> reqError && $stable(flags_ff)) else $error("word immediate not refused");
  a_carry_add: assert property (chkGo_ff && chkReq_ff.op == alu_pkg::OP_ADDC
    |-> dstNow == 8'(chkA_ff + chkB_ff + {7'h00, chkC_ff})) else $error("carry add wrong");
  a_step_byte: assert property (chkGo_ff && chkReq_ff.op == alu_pkg::OP_INCB
    |-> dstNow == 8'(chkA_ff + 8'h01)) else $error("byte step wrong");
  a_word_step: assert property (chkGo_ff && chkReq_ff.op == alu_pkg::OP_WDEC
    |-> wordNow == 16'(chkW_ff - (chkReq_ff.step2 ? 16'h0002 : 16'h0001))) else $error("word step wrong");
  a_mul_full: assert property (chkGo_ff && chkReq_ff.op == alu_pkg::OP_MUL
    |-> wordNow == {8'h00, chkW_ff[7:0]} * {8'h00, chkB_ff}) else $error("product wrong");
  a_div_pair: assert property (chkGo_ff && chkReq_ff.op == alu_pkg::OP_DIV
    && chkW_ff[15:8] < chkB_ff |-> wordNow[15:8] < chkB_ff
    && 16'({8'h00, wordNow[7:0]} * {8'h00, chkB_ff}) + {8'h00, wordNow[15:8]} == chkW_ff)
    else $error("quotient or remainder wrong");
  a_cmp_nostore: assert property (chkGo_ff && chkReq_ff.op == alu_pkg::OP_COMPARE
    && !chkReq_ff.word |-> dstNow == chkA_ff
    && flags_ff[alu_pkg::FLAG_Z] == (chkA_ff == chkB_ff)) else $error("compare altered register");
  a_neg_value: assert property (chkGo_ff && chkReq_ff.op == alu_pkg::OP_NEGATE
    |-> dstNow == 8'(8'h00 - chkA_ff)) else $error("negation wrong");
  a_rot_carry: assert property (chkGo_ff && chkReq_ff.op == alu_pkg::OP_ROTC_L
    |-> {flags_ff[alu_pkg::FLAG_C], dstNow} == {chkA_ff, chkC_ff}) else $error("carry rotate wrong");

  c_word_add: cover property (go && req.op == alu_pkg::OP_ADD && req.word);
  c_div_ok:   cover property (go && req.op == alu_pkg::OP_DIV && !divOvf);
  c_refused:  cover property (reqValid && illegal);
  c_bus_read: cover property (busRd ##1 busRdata != 8'h00);

endmodule

// file: alu_pkg.sv
// Shared constants, operation codes and carriers of the arithmetic unit.
package alu_pkg;

  // ****************************************
  // Register bus map
  // ****************************************
  localparam int          ADDR_W        = 5;
  localparam logic [4:0]  ADDR_GPR_LAST = 5'h0f;
  localparam logic [4:0]  ADDR_FLAGS    = 5'h10;
  localparam logic [7:0]  GPR_RESET     = 8'h00;
  localparam logic [4:0]  FLAGS_RESET   = 5'h00;

  // ****************************************
  // Condition flag positions
  // ****************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_H = 4;

  // ****************************************
  // Operations
  // ****************************************
  typedef enum logic [4:0] {
    OP_ADD      = 5'h00, OP_SUB      = 5'h01, OP_ADDC     = 5'h02,
    OP_SUBB     = 5'h03, OP_INCB     = 5'h04, OP_DECB     = 5'h05,
    OP_WINC     = 5'h06, OP_WDEC     = 5'h07, OP_DADJ_ADD = 5'h08,
    OP_DADJ_SUB = 5'h09, OP_MUL      = 5'h0a, OP_DIV      = 5'h0b,
    OP_COMPARE  = 5'h0c, OP_NEGATE   = 5'h0d, OP_AND      = 5'h0e,
    OP_OR       = 5'h0f, OP_XOR      = 5'h10, OP_INVERT   = 5'h11,
    OP_ASL      = 5'h12, OP_ASR      = 5'h13, OP_LSL      = 5'h14,
    OP_LSR      = 5'h15, OP_ROT_L    = 5'h16, OP_ROT_R    = 5'h17,
    OP_ROTC_L   = 5'h18, OP_ROTC_R   = 5'h19
  } op_e;

  // One instruction from the decoder.
  typedef struct packed {
    op_e        op;
    logic       word;
    logic       immSel;
    logic       step2;
    logic [3:0] dst;
    logic [3:0] src;
    logic [7:0] imm;
  } alu_req_s;

endpackage

// file: div_unit.sv
// Combinational unsigned 16 by 8 restoring divider.
module div_unit (
  // Operands.
  input  wire logic [15:0] dividend,
  input  wire logic [7:0]  divisor,
  // Results.
  output logic      [7:0]  quotient,
  output logic      [7:0]  remainder,
  output logic             overflow
);

  // Quotient fits in eight bits only when the high byte is below the divisor.
  assign overflow = (dividend[15:8] >= divisor);

  // Eight restoring steps, one quotient bit each.
  always_comb begin
    logic [8:0] part;
    logic [7:0] rem;
    part = 9'h000;
    rem = dividend[15:8];
    quotient = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      part = {rem, dividend[i]};
      if (part >= {1'b0, divisor}) begin
        quotient[i] = 1'b1;
        part = part - {1'b0, divisor};
      end
      rem = part[7:0];
    end
    remainder = rem;
  end

endmodule

// file: decoder_model.sv
// Instruction decoder model that hands the core one request per issue pulse.
module decoder_model (
  // Clock and reset.
  input  wire logic              sys_clk,
  input  wire logic              srst,
  // Request from the bench.
  input  wire logic              issue,
  input  wire alu_pkg::alu_req_s reqIn,
  // Request to the core.
  output logic                   reqValid,
  output alu_pkg::alu_req_s      req
);
  timeunit 1ns;
  timeprecision 100ps;

  // Registers a request; idle cycles scramble the fields so a stale request never looks valid.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reqValid <= 1'b0;
      req      <= '0;
    end else begin
      reqValid <= issue;
      req      <= issue ? reqIn : alu_pkg::alu_req_s'(~req);
    end
  end
endmodule

// file: cpu_arith_logic_shift_unit_bench.sv
// Self-checking bench of the arithmetic, logic and shift core.
module cpu_arith_logic_shift_unit_bench;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Signals and instances
  // ****************************************
  logic              sys_clk = 1'b0;
  logic              srst = 1'b1;
  logic              busWr = 1'b0;
  logic              busRd = 1'b0;
  logic              issue = 1'b0;
  logic              rLat = 1'b0;
  logic              vLat = 1'b0;
  logic              fLat = 1'b0;
  logic              reqValid;
  logic              reqError;
  logic [4:0]        busAddr = 5'h00;
  logic [4:0]        condFlags;
  logic [7:0]        busWdata = 8'h00;
  logic [7:0]        busRdata;
  logic [7:0]        mNow;
  logic [7:0]        eNow;
  alu_pkg::alu_req_s req;
  alu_pkg::alu_req_s reqIn = '0;
  logic [7:0]        expQ[$];
  logic [7:0]        mskQ[$];
  logic              errQ[$];
  int                nErrors = 0;
  int                checkCount = 0;
  int                cyc = 0;

  always #2.5 sys_clk = ~sys_clk;

  alu_core i_alu_core (.sys_clk(sys_clk), .srst(srst), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr),
    .busRd(busRd), .busRdata(busRdata), .reqValid(reqValid), .req(req), .reqError(reqError),
    .condFlags(condFlags));
  decoder_model i_decoder_model (.sys_clk(sys_clk), .srst(srst), .issue(issue), .reqIn(reqIn),
    .reqValid(reqValid), .req(req));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tallyAndFinish();
    $display("checks %0d errors %0d", checkCount, nErrors);
    if (nErrors == 0 && checkCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Notes which cycles carry an answer and cuts a hung run short.
  always @(posedge sys_clk) begin
    rLat <= busRd;
    vLat <= reqValid;
    fLat <= busRd && (busAddr == alu_pkg::ADDR_FLAGS); // Flag reads also check the flag port.
    cyc  <= cyc + 1;
    if (cyc == 20000) begin
      nErrors++;
      tallyAndFinish();
    end
  end

  // Compares each answer with the oldest expectation noted by the driver.
  always @(negedge sys_clk) begin
    if (rLat) begin
      mNow = mskQ.pop_front();
      eNow = expQ.pop_front();
      chk("busRdata", busRdata & mNow, eNow);
      if (fLat) chk("condFlags", {3'h0, condFlags} & mNow, eNow);
    end
    if (vLat) chk("reqError", {7'h00, reqError}, {7'h00, errQ.pop_front()});
  end

  // ****************************************
  // Bus and instruction drivers
  // ****************************************
  task automatic wr(logic [4:0] a, logic [7:0] d);
    @(posedge sys_clk);
    busWr    <= 1'b1;
    busAddr  <= a;
    busWdata <= d;
    @(posedge sys_clk);
    busWr    <= 1'b0;
    busWdata <= ~d;
  endtask

  task automatic rd(logic [4:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
    expQ.push_back(e & m);
    mskQ.push_back(m);
    @(posedge sys_clk);
    busRd   <= 1'b1;
    busAddr <= a;
    @(posedge sys_clk);
    busRd   <= 1'b0;
  endtask

  // The model registers the request, so the result lands two edges after the pulse.
  task automatic iss(alu_pkg::alu_req_s r, logic e);
    errQ.push_back(e);
    @(posedge sys_clk);
    issue <= 1'b1;
    reqIn <= r;
    @(posedge sys_clk);
    issue <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // Byte result with the carry out above it.
  function automatic logic [8:0] ref8(alu_pkg::op_e op, logic [7:0] a, logic [7:0] b, logic c);
    case (op)
      alu_pkg::OP_ADD:                      return {1'b0, a} + b;
      alu_pkg::OP_SUB, alu_pkg::OP_COMPARE: return {a < b, a - b};
      alu_pkg::OP_ADDC:                     return {1'b0, a} + b + c;
      alu_pkg::OP_SUBB:                     return {{1'b0, a} < b + c, a - b - c};
      alu_pkg::OP_INCB:                     return {c, a + 8'h01};
      alu_pkg::OP_DECB:                     return {c, a - 8'h01};
      alu_pkg::OP_NEGATE:                   return {a != 8'h00, 8'h00 - a};
      alu_pkg::OP_AND:                      return {c, a & b};
      alu_pkg::OP_OR:                       return {c, a | b};
      alu_pkg::OP_XOR:                      return {c, a ^ b};
      alu_pkg::OP_INVERT:                   return {c, ~a};
      alu_pkg::OP_ASL, alu_pkg::OP_LSL:     return {a, 1'b0};
      alu_pkg::OP_ASR:                      return {a[0], a[7], a[7:1]};
      alu_pkg::OP_LSR:                      return {a[0], 1'b0, a[7:1]};
      alu_pkg::OP_ROT_L:                    return {a, a[7]};
      alu_pkg::OP_ROT_R:                    return {a[0], a[0], a[7:1]};
      alu_pkg::OP_ROTC_L:                   return {a, c};
      alu_pkg::OP_ROTC_R:                   return {a[0], c, a[7:1]};
      default:                              return {c, a};
    endcase
  endfunction

  // Loads operands and carry, runs one byte operation, reads result and N, Z, C back.
  task automatic byteOp(alu_pkg::op_e op, logic im, logic [7:0] a, logic [7:0] b, logic c);
    logic [3:0] d;
    logic [3:0] s;
    logic [8:0] r;
    d = 4'($urandom);
    s = d ^ 4'(1 + $urandom % 15);
    r = ref8(op, a, b, c);
    wr({1'b0, d}, a);
    wr({1'b0, s}, im ? ~b : b);
    // Zero starts set, so carry chains report zero from their own result alone.
    wr(alu_pkg::ADDR_FLAGS, {6'h01, 1'b1, c});
    iss('{op, 1'b0, im, 1'b0, d, s, b}, 1'b0);
    rd({1'b0, d}, op == alu_pkg::OP_COMPARE ? a : r[7:0]);
    rd(alu_pkg::ADDR_FLAGS, {4'h0, r[7], r[7:0] == 8'h00, 1'b0, r[8]}, 8'h0d);
  endtask

  // Runs one word operation on a low word with a source word in the upper half.
  task automatic wordOp(alu_pkg::op_e op, logic st, logic [15:0] x, logic [15:0] y, logic [15:0] e);
    logic [2:0] w;
    logic [2:0] v;
    w = 3'($urandom % 4);
    v = 3'(4 + $urandom % 4);
    wr({1'b0, w, 1'b0}, x[15:8]);
    wr({1'b0, w, 1'b1}, x[7:0]);
    wr({1'b0, v, 1'b0}, y[15:8]);
    wr({1'b0, v, 1'b1}, y[7:0]);
    iss('{op, 1'b1, 1'b0, st, {1'b0, w}, op inside {alu_pkg::OP_MUL, alu_pkg::OP_DIV} ? {v, 1'b1} : {1'b0, v},
      8'h00}, 1'b0);
    rd({1'b0, w, 1'b0}, e[15:8]);
    rd({1'b0, w, 1'b1}, e[7:0]);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  dv;
    logic [15:0] x;
    logic [15:0] y;
    void'($urandom(87746));
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    // Reset values, then an unmapped place that must read zero.
    for (int i = 0; i < 17; i++) rd(5'(i), 8'h00);
    wr(5'h15, 8'hff);
    rd(5'h15, 8'h00);
    // Every byte operation but decimal adjust, with register and, where allowed, immediate source.
    for (int i = 0; i < 26; i++) begin
      if (i inside {[6:11]}) continue;
      for (int k = 0; k < 4; k++) begin
        a = k == 0 ? 8'hff : 8'($urandom);
        b = k == 0 ? 8'h01 : 8'($urandom);
        byteOp(alu_pkg::op_e'(i), k[0] && (i inside {0, 2, 3, 12, 14, 15, 16}), a, b, k[1]);
      end
    end
    // Word operations, the step size, multiply and divide.
    for (int k = 0; k < 2; k++) begin
      x = 16'($urandom);
      y = 16'($urandom);
      dv = y[7:0] | 8'h80;
      wordOp(alu_pkg::OP_ADD, 1'b0, x, y, x + y);
      wordOp(alu_pkg::OP_SUB, 1'b0, x, y, x - y);
      wordOp(alu_pkg::OP_COMPARE, 1'b0, x, y, x);
      wordOp(alu_pkg::OP_WINC, k[0], x, y, x + 16'(k + 1));
      wordOp(alu_pkg::OP_WDEC, k[0], x, y, x - 16'(k + 1));
      wordOp(alu_pkg::OP_MUL, 1'b0, x, y, 16'(x[7:0]) * 16'(y[7:0]));
      x[15] = 1'b0;
      wordOp(alu_pkg::OP_DIV, 1'b0, x, {8'h00, dv}, {8'(x % dv), 8'(x / dv)});
      wordOp(alu_pkg::OP_DIV, 1'b0, x, 16'h0000, x);
    end
    // Decimal adjust after an addition and after a subtraction.
    wr(5'h00, 8'h19);
    wr(5'h01, 8'h28);
    iss('{alu_pkg::OP_ADD, 1'b0, 1'b0, 1'b0, 4'h0, 4'h1, 8'h00}, 1'b0);
    iss('{alu_pkg::OP_DADJ_ADD, 1'b0, 1'b0, 1'b0, 4'h0, 4'h1, 8'h00}, 1'b0);
    rd(5'h00, 8'h47);
    iss('{alu_pkg::OP_SUB, 1'b0, 1'b0, 1'b0, 4'h0, 4'h1, 8'h00}, 1'b0);
    iss('{alu_pkg::OP_DADJ_SUB, 1'b0, 1'b0, 1'b0, 4'h0, 4'h1, 8'h00}, 1'b0);
    rd(5'h00, 8'h19);
    // Refused forms leave registers and flags untouched.
    wr(5'h02, 8'h3c);
    wr(5'h03, 8'hc5);
    wr(alu_pkg::ADDR_FLAGS, 8'h1f);
    iss('{alu_pkg::OP_SUB, 1'b0, 1'b1, 1'b0, 4'h2, 4'h3, 8'h11}, 1'b1);
    iss('{alu_pkg::OP_ADD, 1'b1, 1'b1, 1'b0, 4'h1, 4'h3, 8'h11}, 1'b1);
    iss('{alu_pkg::OP_AND, 1'b1, 1'b0, 1'b0, 4'h1, 4'h2, 8'h00}, 1'b1);
    iss('{alu_pkg::OP_COMPARE, 1'b1, 1'b1, 1'b0, 4'h1, 4'h3, 8'h11}, 1'b1);
    rd(5'h02, 8'h3c);
    rd(5'h03, 8'hc5);
    rd(alu_pkg::ADDR_FLAGS, 8'h1f);
    repeat (3) @(posedge sys_clk);
    tallyAndFinish();
  end
endmodule
